/* File: verilog/flow_cmd_pkg.sv */
package flow_cmd_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_SLEEP     = 16'h3677;
  localparam logic [15:0] CMD_IDENT     = 16'hE102;
  localparam logic [15:0] CMD_STOP      = 16'h3FF9;
  localparam logic [15:0] CMD_START_O2  = 16'h3603;
  localparam logic [15:0] CMD_START_AIR = 16'h3608;
  localparam logic [15:0] CMD_START_MIX = 16'h3632;
  localparam logic [15:0] CMD_SCALE     = 16'h3661;
  localparam logic [7:0]  GC_RESET      = 8'h06;
  // ----------------------------------------------------------------
  // crc
  // ----------------------------------------------------------------
  localparam logic [7:0]  CRC_POLY      = 8'h31;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [7:0]  CRC_XOROUT    = 8'h00;
  // ----------------------------------------------------------------
  // number formats
  // ----------------------------------------------------------------
  localparam logic [15:0] FLOW_SCALE    = 16'd170;
  localparam logic [15:0] FLOW_OFFSET   = 16'hA000;
  localparam logic [15:0] TEMP_SCALE    = 16'd200;
  localparam logic [15:0] TEMP_OFFSET   = 16'h0000;
  localparam int          UNIT_PFX_LSB  = 0;
  localparam int          UNIT_TB_LSB   = 4;
  localparam int          UNIT_U_LSB    = 8;
  localparam logic [3:0]  UNIT_PFX_VAL  = 4'h8;
  localparam logic [3:0]  UNIT_TB_VAL   = 4'h4;
  localparam logic [4:0]  UNIT_U_VAL    = 5'h01;
  localparam logic [15:0] FLOW_UNIT     = {3'h0, UNIT_U_VAL, UNIT_TB_VAL, UNIT_PFX_VAL};
  // ----------------------------------------------------------------
  // identity
  // ----------------------------------------------------------------
  localparam logic [31:0] PRODUCT_NUM   = 32'h0A0B0C10; // arbitrary value
  localparam logic [63:0] SERIAL_NUM    = 64'h0000_0000_1234_5678; // arbitrary
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          STOP_US       = 500;
  localparam int          STOP_CYC      = (STOP_US * (CLK_HZ / 1_000_000));
  localparam int          FIFO_DEPTH    = 8;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MEAS  = 2'b01,
    ST_SLEEP = 2'b10,
    ST_STOP  = 2'b11
  } mode_e;
endpackage : flow_cmd_pkg

/* File: verilog/crc8_step.sv */
`timescale 1ns/100ps
module crc8_step
  import flow_cmd_pkg::*;
(
  input  wire logic [7:0] i_crc,
  input  wire logic [7:0] i_byte,
  output logic      [7:0] o_crc
);
  // ----------------------------------------------------------------
  // one byte, msb first, no reflection
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    c = i_crc ^ i_byte;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    o_crc = c;
  end
endmodule : crc8_step

/* File: verilog/byte_fifo.sv */
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_clr,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_s;
  fifo_s st_q, st_d;
  logic  push, pop;
  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign o_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign o_valid = (st_q.cnt != '0);
  assign o_data  = st_q.mem[st_q.rp];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = i_data;
      st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_clr) begin
      st_d.wp  = '0;
      st_d.rp  = '0;
      st_d.cnt = '0;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : byte_fifo

/* File: verilog/flow_cmd_core.sv */
`timescale 1ns/100ps
// Function
// - enter-sleep command puts idle sensor to sleep
// - sleep command refused unless idle
// - soft reset ignored while sleeping
// - own address with write wakes to idle
// - waking address transfer is not acknowledged
// - identifier command accepted only when idle
// - identifier returns 32-bit product, 64-bit serial
// - serial decimal reads year, week, sequence
// - product last digits: 8x prototype, 1x final
// - crc byte after every data word
// - crc poly 0x31, init FF, no reflect
// - flow is 16-bit two's complement
// - flow scale 170, offset -24576
// - temperature scale 200, offset zero
// - unit word: prefix, time base, unit fields
// - flow unit reads fixed 0x0148
// - stop command returns to idle within 0.5ms
module flow_cmd_core
  import flow_cmd_pkg::*;
#(
  parameter int STOP_CYCLES = STOP_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_addr_wr,
  input  wire logic        i_gc_valid,
  input  wire logic [7:0]  i_gc_byte,
  input  wire logic        i_wr_valid,
  input  wire logic [7:0]  i_wr_byte,
  input  wire logic        i_stop,
  input  wire logic        i_rd_ready,
  input  wire logic [15:0] i_flow,
  input  wire logic [15:0] i_temp,
  output logic             o_addr_ack,
  output logic             o_wr_ready,
  output logic             o_rd_valid,
  output logic      [7:0]  o_rd_byte,
  output logic             o_soft_reset,
  output logic             o_sleeping,
  output logic             o_measuring,
  output logic             o_busy,
  output logic             o_cmd_refused
);
  typedef struct packed {
    mode_e       mode;
    logic [15:0] cmd;
    logic        half;
    logic [3:0]  nwords;
    logic [5:0][15:0] words;
    logic [3:0]  widx;
    logic [1:0]  phase;
    logic [7:0]  crc;
    logic [15:0] arg;
    logic        scale_pend;
    logic [$clog2(STOP_CYCLES+1)-1:0] tmr;
    logic        rst_p;
    logic        refused;
  } core_s;
  core_s       st_q, st_d;
  logic [7:0]  crc_next;
  logic [7:0]  cur_byte;
  logic        f_valid;
  logic        f_ready;
  logic        loading;
  logic [15:0] cur_word;
  logic [15:0] full_cmd;
  // ----------------------------------------------------------------
  // serialiser byte selection
  // ----------------------------------------------------------------
  assign cur_word = (st_q.widx < 4'h6) ? st_q.words[st_q.widx[2:0]] : 16'h0000;
  always_comb begin
    unique case (st_q.phase)
      2'd0:    cur_byte = cur_word[15:8];
      2'd1:    cur_byte = cur_word[7:0];
      default: cur_byte = st_q.crc ^ CRC_XOROUT;
    endcase
  end
  crc8_step u_crc (
    .i_crc  (st_q.crc),
    .i_byte (cur_byte),
    .o_crc  (crc_next)
  );
  assign loading = (st_q.widx != st_q.nwords);
  assign f_valid = loading;
  byte_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_clr   (i_wr_valid),
    .i_valid (f_valid),
    .o_ready (f_ready),
    .i_data  (cur_byte),
    .o_valid (o_rd_valid),
    .i_ready (i_rd_ready),
    .o_data  (o_rd_byte)
  );
  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign o_addr_ack    = i_addr_wr && (st_q.mode != ST_SLEEP);
  assign o_wr_ready    = (st_q.mode != ST_STOP);
  assign o_sleeping    = (st_q.mode == ST_SLEEP);
  assign o_measuring   = (st_q.mode == ST_MEAS);
  assign o_busy        = (st_q.mode == ST_STOP);
  assign o_soft_reset  = st_q.rst_p;
  assign o_cmd_refused = st_q.refused;
  assign full_cmd      = {st_q.cmd[7:0], i_wr_byte};
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.rst_p   = 1'b0;
    st_d.refused = 1'b0;
    if (loading && f_ready) begin
      st_d.crc = (st_q.phase == 2'd2) ? CRC_INIT : crc_next;
      if (st_q.phase == 2'd2) begin
        st_d.phase = 2'd0;
        st_d.widx  = st_q.widx + 4'd1;
      end else begin
        st_d.phase = st_q.phase + 2'd1;
      end
    end
    if (i_gc_valid && i_gc_byte == GC_RESET && st_q.mode != ST_SLEEP) begin
      st_d.rst_p = 1'b1;
      st_d.mode  = ST_IDLE;
    end
    unique case (st_q.mode)
      ST_SLEEP: begin
        if (i_addr_wr) begin
          st_d.mode = ST_IDLE;
        end
      end
      ST_STOP: begin
        st_d.tmr = st_q.tmr - 1'b1;
        if (st_q.tmr == '0) begin
          st_d.mode = ST_IDLE;
        end
      end
      ST_MEAS: begin
        if (!loading && st_q.nwords != 4'd0) begin
          st_d.words[0] = i_flow;
          st_d.words[1] = i_temp;
          st_d.nwords   = 4'd2;
          st_d.widx     = 4'd0;
        end
      end
      ST_IDLE: begin
      end
    endcase
    if (i_addr_wr) begin
      st_d.half = 1'b0;
    end
    if (i_wr_valid && o_wr_ready && st_q.mode != ST_SLEEP) begin
      st_d.cmd    = {st_q.cmd[7:0], i_wr_byte};
      st_d.half   = ~st_q.half;
      st_d.nwords = 4'd0;
      st_d.widx   = 4'd0;
      st_d.phase  = 2'd0;
      st_d.crc    = CRC_INIT;
      if (st_q.half && st_q.scale_pend) begin
        st_d.arg        = full_cmd;
        st_d.scale_pend = 1'b0;
        st_d.words[0]   = FLOW_SCALE;
        st_d.words[1]   = FLOW_OFFSET;
        st_d.words[2]   = FLOW_UNIT;
        st_d.nwords     = 4'd3;
      end else if (st_q.half) begin
        if (full_cmd == CMD_STOP && st_q.mode == ST_MEAS) begin
          st_d.mode = ST_STOP;
          st_d.tmr  = ($bits(st_q.tmr))'(STOP_CYCLES - 1);
        end else if (st_q.mode == ST_MEAS) begin
          st_d.refused = 1'b1;
        end else if (full_cmd == CMD_SLEEP) begin
          st_d.mode = ST_SLEEP;
        end else if (full_cmd == CMD_IDENT) begin
          st_d.words[0] = PRODUCT_NUM[31:16];
          st_d.words[1] = PRODUCT_NUM[15:0];
          st_d.words[2] = SERIAL_NUM[63:48];
          st_d.words[3] = SERIAL_NUM[47:32];
          st_d.words[4] = SERIAL_NUM[31:16];
          st_d.words[5] = SERIAL_NUM[15:0];
          st_d.nwords   = 4'd6;
        end else if (full_cmd == CMD_START_O2 || full_cmd == CMD_START_AIR ||
                     full_cmd == CMD_START_MIX) begin
          st_d.mode     = ST_MEAS;
          st_d.words[0] = i_flow;
          st_d.words[1] = i_temp;
          st_d.nwords   = 4'd2;
        end else if (full_cmd == CMD_SCALE) begin
          st_d.scale_pend = 1'b1;
        end else begin
          st_d.refused = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : flow_cmd_core

/* File: sim/flow_cmd_core_asserts.sv */
`timescale 1ns/100ps
module flow_cmd_core_asserts
  import flow_cmd_pkg::*;
#(
  parameter int STOP_CYCLES = STOP_CYC
) (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_addr_wr,
  input wire logic       i_gc_valid,
  input wire logic [7:0] i_gc_byte,
  input wire logic       i_wr_valid,
  input wire logic       i_rd_ready,
  input wire logic       o_addr_ack,
  input wire logic       o_wr_ready,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_rd_byte,
  input wire logic       o_soft_reset,
  input wire logic       o_sleeping,
  input wire logic       o_measuring,
  input wire logic       o_busy,
  input wire logic       o_cmd_refused
);
  // ----------------------------------------------------------------
  // settle length counter
  // ----------------------------------------------------------------
  logic [15:0] busy_cnt_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= o_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wake_nack_a: assert property (
    i_addr_wr && o_sleeping |-> !o_addr_ack) else $error("wake address acked");
  addr_ack_a: assert property (
    i_addr_wr && !o_sleeping |-> o_addr_ack) else $error("idle address not acked");
  wake_idle_a: assert property (
    i_addr_wr && o_sleeping |=> !o_sleeping && !o_measuring) else $error("no wake");
  sleep_reset_a: assert property (
    i_gc_valid && i_gc_byte == GC_RESET && o_sleeping |=> (!o_soft_reset && o_sleeping) [*2])
    else $error("reset while asleep");
  sleep_entry_a: assert property (
    $rose(o_sleeping) |-> !$past(o_measuring) && !$past(o_busy)) else $error("bad sleep");
  refuse_meas_a: assert property (
    o_cmd_refused |-> $past(o_measuring)) else $error("refusal outside measuring");
  sleep_quiet_a: assert property (
    o_sleeping |-> !o_measuring && !o_busy) else $error("active while asleep");
  stop_len_a: assert property (
    busy_cnt_q <= STOP_CYCLES) else $error("settle too long");
  stop_gate_a: assert property (
    o_busy |-> !o_wr_ready) else $error("ready while settling");
  rd_hold_a: assert property (
    o_rd_valid && !i_rd_ready && !i_wr_valid && !i_addr_wr && !i_gc_valid
    |=> o_rd_valid && $stable(o_rd_byte)) else $error("read byte lost");
  wake_c: cover property (i_addr_wr && o_sleeping);
  refuse_c: cover property (o_cmd_refused);
  settle_c: cover property ($fell(o_busy));
endmodule : flow_cmd_core_asserts

bind flow_cmd_core flow_cmd_core_asserts #(.STOP_CYCLES(STOP_CYCLES)) u_chk (
  .i_clk, .i_nrst, .i_addr_wr, .i_gc_valid, .i_gc_byte, .i_wr_valid, .i_rd_ready,
  .o_addr_ack, .o_wr_ready, .o_rd_valid, .o_rd_byte, .o_soft_reset, .o_sleeping,
  .o_measuring, .o_busy, .o_cmd_refused);

/* File: sim/host_model.sv */
`timescale 1ns/100ps
module host_model
  import flow_cmd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_wr_ready,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_byte,
  input  wire logic       i_addr_ack,
  output logic            o_addr_wr,
  output logic            o_gc_valid,
  output logic      [7:0] o_gc_byte,
  output logic            o_wr_valid,
  output logic      [7:0] o_wr_byte,
  output logic            o_rd_ready
);
  initial begin
    {o_addr_wr, o_gc_valid, o_gc_byte, o_wr_valid, o_wr_byte, o_rd_ready} = '0;
  end
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c ^ CRC_XOROUT;
  endfunction : crc8
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    o_wr_valid = 1'b1;
    o_wr_byte = b;
    while (!i_wr_ready && n < 200) begin
      @(posedge i_clk) #1;
      n++;
    end
    @(posedge i_clk) #1;
  endtask : put
  task automatic cmd(input logic [15:0] c);
    @(posedge i_clk) #1;
    put(c[15:8]);
    put(c[7:0]);
    o_wr_valid = 1'b0;
    o_wr_byte = ~o_wr_byte;
  endtask : cmd
  task automatic get(output logic [15:0] w, output logic ok);
    logic [7:0] b [3];
    int n;
    @(posedge i_clk) #1;
    o_rd_ready = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (!i_rd_valid && n < 200) begin
        @(posedge i_clk) #1;
        n++;
      end
      b[k] = i_rd_byte;
      @(posedge i_clk) #1;
    end
    o_rd_ready = 1'b0;
    w = {b[0], b[1]};
    ok = (crc8(w) === b[2]);
  endtask : get
  task automatic poke(output logic ack);
    @(posedge i_clk) #1;
    o_addr_wr = 1'b1;
    #1 ack = i_addr_ack;
    @(posedge i_clk) #1;
    o_addr_wr = 1'b0;
  endtask : poke
  task automatic wake(output int tries);
    logic a;
    tries = 0;
    do begin
      poke(a);
      tries++;
    end while (!a && tries < 20);
  endtask : wake
  task automatic gcall(input logic [7:0] b);
    @(posedge i_clk) #1;
    o_gc_valid = 1'b1;
    o_gc_byte = b;
    @(posedge i_clk) #1;
    o_gc_valid = 1'b0;
    o_gc_byte = ~b;
  endtask : gcall
endmodule : host_model

/* File: sim/flow_cmd_core_tb.sv */
`timescale 1ns/100ps
module flow_cmd_core_tb;
  import flow_cmd_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_addr_wr, i_gc_valid, i_wr_valid, i_rd_ready;
  logic [7:0]  i_gc_byte, i_wr_byte, o_rd_byte;
  logic [15:0] i_flow = 16'h8123;
  logic [15:0] i_temp = 16'h1388;
  logic        o_addr_ack, o_wr_ready, o_rd_valid, o_soft_reset;
  logic        o_sleeping, o_measuring, o_busy, o_cmd_refused;
  int          error_cnt, num_checks, ref_cnt, rst_cnt;
  flow_cmd_core #(.STOP_CYCLES(8)) DUT (
    .i_clk, .i_nrst, .i_addr_wr, .i_gc_valid, .i_gc_byte, .i_wr_valid, .i_wr_byte,
    .i_stop(1'b0), .i_rd_ready, .i_flow, .i_temp, .o_addr_ack, .o_wr_ready, .o_rd_valid,
    .o_rd_byte, .o_soft_reset, .o_sleeping, .o_measuring, .o_busy, .o_cmd_refused);
  host_model u_host (
    .i_clk, .i_wr_ready(o_wr_ready), .i_rd_valid(o_rd_valid), .i_rd_byte(o_rd_byte),
    .i_addr_ack(o_addr_ack), .o_addr_wr(i_addr_wr), .o_gc_valid(i_gc_valid),
    .o_gc_byte(i_gc_byte), .o_wr_valid(i_wr_valid), .o_wr_byte(i_wr_byte),
    .o_rd_ready(i_rd_ready));
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_cmd_refused === 1'b1) ref_cnt++;
    if (o_soft_reset === 1'b1) rst_cnt++;
  end
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic t_ident();
    logic [15:0] w;
    logic        ok;
    logic [95:0] got;
    check(u_host.crc8(16'hBEEF), 8'h92);
    u_host.cmd(CMD_IDENT);
    for (int i = 0; i < 6; i++) begin
      u_host.get(w, ok);
      got = {got[79:0], w};
      check(ok, 1'b1);
    end
    check(got, {PRODUCT_NUM, SERIAL_NUM});
    check(got[71:68] inside {4'h1, 4'h8}, 1'b1);
    check(got[63:0] < 64'h2540BE400 && ((got[63:0] / 64'hF4240) % 64'h64) inside {[64'h1:64'h35]}, 1'b1);
  endtask : t_ident
  task automatic t_scale();
    logic [15:0] gas [3] = '{16'h3603, 16'h3608, 16'h3632};
    logic [15:0] w [3];
    logic        ok;
    for (int g = 0; g < 3; g++) begin
      u_host.cmd(CMD_SCALE);
      u_host.cmd(gas[g]);
      for (int i = 0; i < 3; i++) begin
        u_host.get(w[i], ok);
        check(ok, 1'b1);
      end
      check({w[0], w[1]}, {16'd170, 16'hA000});
      check(w[2], 16'h0148);
      check({w[2][12:8], w[2][7:4], w[2][3:0]}, {5'h01, 4'h4, 4'h8});
    end
  endtask : t_scale
  task automatic t_meas();
    logic [15:0] w;
    logic        ok;
    int          r;
    int          n;
    u_host.cmd(16'h3608);
    u_host.get(w, ok);
    check(w, i_flow);
    u_host.get(w, ok);
    check(w, i_temp);
    r = ref_cnt;
    u_host.cmd(CMD_SLEEP);
    settle(3);
    check({ref_cnt, o_sleeping}, {r + 1, 1'b0});
    u_host.cmd(CMD_IDENT);
    settle(3);
    check(ref_cnt, r + 2);
    u_host.cmd(CMD_STOP);
    check({o_busy, o_wr_ready}, 2'b10);
    n = 0;
    while (o_wr_ready !== 1'b1 && n < 50) begin
      settle(1);
      n++;
    end
    check({n <= 9, o_measuring}, 2'b10);
  endtask : t_meas
  task automatic t_sleep();
    logic a;
    int   r;
    int   n;
    u_host.cmd(CMD_SLEEP);
    settle(2);
    check(o_sleeping, 1'b1);
    r = rst_cnt;
    u_host.gcall(GC_RESET);
    settle(3);
    check({rst_cnt, o_sleeping}, {r, 1'b1});
    u_host.poke(a);
    check(a, 1'b0);
    settle(2);
    check(o_sleeping, 1'b0);
    u_host.wake(n);
    check(n, 1);
    u_host.gcall(GC_RESET);
    settle(3);
    check(rst_cnt, r + 1);
  endtask : t_sleep
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    t_ident();
    t_scale();
    t_meas();
    t_sleep();
    tally_and_finish();
  end
endmodule : flow_cmd_core_tb
